/* File: verilog/ustx_pkg.sv */
// Package for the serial transmitter: APB register map, field positions,
// reset values and the frame state enumeration.
// Assumes a 32-bit APB bus with word-aligned registers.
`default_nettype none
package ustx_pkg;
  localparam logic [7:0] ADDR_DATA    = 8'h00;
  localparam logic [7:0] ADDR_CSA     = 8'h04;
  localparam logic [7:0] ADDR_CSB     = 8'h08;
  localparam logic [7:0] ADDR_CSC     = 8'h0c;
  localparam logic [7:0] ADDR_BAUD    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ACK = 8'h14;
  // ctrl_status_a
  localparam int CSA_DOUBLE   = 1;
  localparam int CSA_BUF_EMPT = 5;
  localparam int CSA_TX_DONE  = 6;
  // ctrl_status_b
  localparam int CSB_NINTH    = 0;
  localparam int CSB_TX_EN    = 3;
  localparam int CSB_TXC_IE   = 6;
  localparam int CSB_BE_IE    = 5;
  // ctrl_status_c
  localparam int CSC_POL      = 0;
  localparam int CSC_SIZE_LO  = 1;
  localparam int CSC_STOP2    = 3;
  localparam int CSC_PAR_ODD  = 4;
  localparam int CSC_PAR_EN   = 5;
  localparam int CSC_SYNC     = 6;
  localparam int CSC_SIZE_HI  = 7;
  localparam logic [7:0]  CSC_RESET  = 8'h06;
  localparam logic [11:0] BAUD_RESET = 12'h000;
  localparam logic [2:0]  SIZE_NINE  = 3'h7;
  localparam logic [4:0]  DIV_NORMAL = 5'h10;
  localparam logic [4:0]  DIV_DOUBLE = 5'h08;
  localparam logic [4:0]  DIV_SYNC   = 5'h02;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} ustx_state_t;
endpackage
`default_nettype wire

/* File: verilog/ustx_tick_if.sv */
// Bit-tick carrier between the transmitter core and its tick generator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ustx_tick_if;
  logic tick;
  logic active;
  modport gen  (output tick, input active);
  modport core (input tick, output active);
endinterface
`default_nettype wire

/* File: verilog/ustx_tick_gen.sv */
// Bit tick generator: baud down-counter, mode divider and external clock edges.
// Assumes serial_clock_in is already synchronised to mclk.
`timescale 1ns/100ps
`default_nettype none
module ustx_tick_gen (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [11:0] baud_divisor,
  input  wire logic        baud_load,
  input  wire logic        double_speed_bit,
  input  wire logic        sync_mode,
  input  wire logic        clock_slave,
  input  wire logic        clock_polarity_bit,
  input  wire logic        serial_clock_in,
  output logic             clk_out,
  ustx_tick_if.gen         tk
);
  import ustx_pkg::*;
  logic [11:0] cnt_reg, cnt_next;
  logic [4:0]  sub_reg, sub_next;
  logic        xck_d_reg, xck_d_next;
  logic        clk_reg, clk_next;
  logic [4:0]  div;
  logic        btick, ext_edge;

  always_comb begin
    div = sync_mode ? DIV_SYNC : (double_speed_bit ? DIV_DOUBLE : DIV_NORMAL);
    btick = (cnt_reg == 12'h000);
    cnt_next = (btick || baud_load) ? baud_divisor : cnt_reg - 12'h001;
    sub_next = sub_reg;
    if (!tk.active) begin
      sub_next = 5'h00;
    end else if (btick) begin
      sub_next = (sub_reg == div - 5'h01) ? 5'h00 : sub_reg + 5'h01;
    end
    // Master clock idles opposite the polarity and toggles on every baud tick,
    // so its first edge samples the start bit and data moves with the second
    clk_next = ~clock_polarity_bit;
    if (tk.active) begin
      clk_next = btick ? ~clk_reg : clk_reg;
    end
    xck_d_next = serial_clock_in;
    // Data changes on the rising edge for polarity zero, falling otherwise
    ext_edge = clock_polarity_bit ? (xck_d_reg && !serial_clock_in)
                                  : (!xck_d_reg && serial_clock_in);
    if (sync_mode && clock_slave) begin
      tk.tick = ext_edge;
    end else begin
      tk.tick = tk.active && btick && (sub_reg == div - 5'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_reg   <= BAUD_RESET;
      sub_reg   <= 5'h00;
      xck_d_reg <= 1'b0;
      clk_reg   <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      sub_reg   <= sub_next;
      xck_d_reg <= xck_d_next;
      clk_reg   <= clk_next;
    end
  end

  assign clk_out = clk_reg;
endmodule
`default_nettype wire

/* File: verilog/ustx_top.sv */
// Serial transmitter with APB register access, one-entry transmit buffer,
// shift register framing, buffer-empty and complete flags with requests.
// Assumes a single 50 MHz mclk; the receiver lives elsewhere.
//
// Behaviour
// - Enable takes serial output pin from port
// - Sync mode times bits from serial clock
// - Data write loads buffer, requests send
// - Buffer moves to shifter when idle/done
// - Shifter sends frame at selected rate
// - Short characters drop upper written bits
// - Buffer-empty flag tracks buffer occupancy
// - Empty request while flag and enable
// - Data write clears buffer-empty flag
// - Complete flag set when all sent
// - Complete clears on service or one-write
// - Complete request when flag and enable
// - Parity bit after data when enabled
// - Disable waits until nothing left
// - Disabled transmitter releases the pin
// - Start, data LSB first, parity, stops
// - Parity is xor, inverted for odd
// - Bit clock divides baud by 16/8/2
// - Sync data edge chosen by polarity
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module ustx_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_irq_en,
  input  wire logic        port_out,
  input  wire logic        port_oe,
  input  wire logic        serial_clock_pin_i,
  input  wire logic        serial_clock_port_out,
  input  wire logic        serial_clock_port_oe,
  input  wire logic        serial_clock_master,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             irq_buffer_empty,
  output logic             irq_tx_complete,
  input  wire logic        irq_tx_complete_ack
);
  import ustx_pkg::*;

  ustx_tick_if tk ();

  logic [7:0]  csc_reg, csc_next;
  logic [11:0] baud_reg, baud_next;
  logic        dbl_reg, dbl_next;
  logic        en_reg, en_next;
  logic        ninth_reg, ninth_next;
  logic        beie_reg, beie_next;
  logic        tcie_reg, tcie_next;
  logic [8:0]  buf_reg, buf_next;
  logic        full_reg, full_next;
  logic        done_reg, done_next;
  logic        live_reg, live_next;
  ustx_state_t st_reg, st_next;
  logic [8:0]  sh_reg, sh_next;
  logic [3:0]  bit_reg, bit_next;
  logic        par_reg, par_next;
  logic        line_reg, line_next;
  logic        stop2_reg, stop2_next;
  logic [31:0] rd_reg, rd_next;
  logic        xs1_reg, xs2_reg;
  logic        wr, rd, sync_mode, load_sh, frame_end;
  logic [2:0]  size;
  logic [3:0]  nbits;

  function automatic logic [8:0] size_mask(input logic [2:0] code);
    case (code)
      3'h0:    size_mask = 9'h01f;
      3'h1:    size_mask = 9'h03f;
      3'h2:    size_mask = 9'h07f;
      3'h3:    size_mask = 9'h0ff;
      3'h7:    size_mask = 9'h1ff;
      default: size_mask = 9'h0ff;
    endcase
  endfunction

  function automatic logic [3:0] size_bits(input logic [2:0] code);
    case (code)
      3'h0:    size_bits = 4'h5;
      3'h1:    size_bits = 4'h6;
      3'h2:    size_bits = 4'h7;
      3'h7:    size_bits = 4'h9;
      default: size_bits = 4'h8;
    endcase
  endfunction

  assign wr        = psel && penable && pwrite;
  assign rd        = psel && !penable && !pwrite;
  assign size      = {csc_reg[CSC_SIZE_HI], csc_reg[CSC_SIZE_LO+1], csc_reg[CSC_SIZE_LO]};
  assign nbits     = size_bits(size);
  assign sync_mode = csc_reg[CSC_SYNC];
  assign tk.active = (st_reg != ST_IDLE) && !(sync_mode && !serial_clock_master);
  assign frame_end = tk.tick && (st_reg == ST_STOP) && !stop2_reg;
  assign load_sh   = full_reg && live_reg && ((st_reg == ST_IDLE) || frame_end);

  // Register state and buffer
  always_comb begin
    csc_next   = csc_reg;
    baud_next  = baud_reg;
    dbl_next   = dbl_reg;
    en_next    = en_reg;
    ninth_next = ninth_reg;
    beie_next  = beie_reg;
    tcie_next  = tcie_reg;
    buf_next   = buf_reg;
    full_next  = full_reg;
    done_next  = done_reg;
    if (load_sh) begin
      full_next = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        ADDR_DATA: begin
          buf_next  = {ninth_reg, pwdata[7:0]} & size_mask(size);
          full_next = 1'b1;
        end
        ADDR_CSA: begin
          dbl_next = pwdata[CSA_DOUBLE];
          if (pwdata[CSA_TX_DONE]) begin
            done_next = 1'b0;
          end
        end
        ADDR_CSB: begin
          ninth_next = pwdata[CSB_NINTH];
          en_next    = pwdata[CSB_TX_EN];
          beie_next  = pwdata[CSB_BE_IE];
          tcie_next  = pwdata[CSB_TXC_IE];
        end
        ADDR_CSC:  csc_next  = pwdata[7:0];
        ADDR_BAUD: baud_next = pwdata[11:0];
        default: begin
        end
      endcase
    end
    if (irq_tx_complete_ack) begin
      done_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (live_reg && frame_end && !full_reg) begin
      done_next = 1'b1;
    end
  end

  // Deferred disable: stays live until shifter and buffer are drained
  always_comb begin
    live_next = live_reg;
    if (en_reg) begin
      live_next = 1'b1;
    end else if (!full_reg && (st_reg == ST_IDLE)) begin
      live_next = 1'b0;
    end
  end

  // Frame shifter
  always_comb begin
    st_next    = st_reg;
    sh_next    = sh_reg;
    bit_next   = bit_reg;
    par_next   = par_reg;
    line_next  = line_reg;
    stop2_next = stop2_reg;
    if (load_sh) begin
      st_next   = ST_START;
      sh_next   = buf_reg;
      bit_next  = 4'h0;
      par_next  = ^buf_reg ^ csc_reg[CSC_PAR_ODD];
      line_next = 1'b0;
    end else if (tk.tick) begin
      unique case (st_reg)
        ST_IDLE: line_next = 1'b1;
        ST_START, ST_DATA: begin
          if (st_reg == ST_DATA && bit_reg == nbits) begin
            st_next   = csc_reg[CSC_PAR_EN] ? ST_PARITY : ST_STOP;
            line_next = csc_reg[CSC_PAR_EN] ? par_reg : 1'b1;
            stop2_next = csc_reg[CSC_STOP2];
          end else begin
            st_next   = ST_DATA;
            line_next = sh_reg[0];
            sh_next   = {1'b0, sh_reg[8:1]};
            bit_next  = bit_reg + 4'h1;
          end
        end
        ST_PARITY: begin
          st_next    = ST_STOP;
          line_next  = 1'b1;
          stop2_next = csc_reg[CSC_STOP2];
        end
        ST_STOP: begin
          if (stop2_reg) begin
            stop2_next = 1'b0;
          end else begin
            st_next   = ST_IDLE;
            line_next = 1'b1;
          end
        end
      endcase
    end
  end

  // Read mux, registered in the setup cycle
  always_comb begin
    rd_next = rd_reg;
    if (rd) begin
      unique case (paddr)
        ADDR_CSA:  rd_next = {25'h0, done_reg, !full_reg, 3'h0, dbl_reg, 1'b0};
        ADDR_CSB:  rd_next = {25'h0, tcie_reg, beie_reg, 1'b0, en_reg, 2'h0, ninth_reg};
        ADDR_CSC:  rd_next = {24'h0, csc_reg};
        ADDR_BAUD: rd_next = {20'h0, baud_reg};
        default:   rd_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      csc_reg <= CSC_RESET;  baud_reg <= BAUD_RESET;
      dbl_reg <= 1'b0;  en_reg <= 1'b0;  ninth_reg <= 1'b0;
      beie_reg <= 1'b0;  tcie_reg <= 1'b0;
      buf_reg <= 9'h000;  full_reg <= 1'b0;  done_reg <= 1'b0;  live_reg <= 1'b0;
      st_reg <= ST_IDLE;  sh_reg <= 9'h000;  bit_reg <= 4'h0;
      par_reg <= 1'b0;  line_reg <= 1'b1;  stop2_reg <= 1'b0;
      rd_reg <= 32'h0;  xs1_reg <= 1'b0;  xs2_reg <= 1'b0;
    end else begin
      csc_reg <= csc_next;  baud_reg <= baud_next;
      dbl_reg <= dbl_next;  en_reg <= en_next;  ninth_reg <= ninth_next;
      beie_reg <= beie_next;  tcie_reg <= tcie_next;
      buf_reg <= buf_next;  full_reg <= full_next;  done_reg <= done_next;
      live_reg <= live_next;
      st_reg <= st_next;  sh_reg <= sh_next;  bit_reg <= bit_next;
      par_reg <= par_next;  line_reg <= line_next;  stop2_reg <= stop2_next;
      rd_reg <= rd_next;
      xs1_reg <= serial_clock_pin_i;
      xs2_reg <= xs1_reg;
    end
  end

  ustx_tick_gen u_tick (
    .mclk               (mclk),
    .reset              (reset),
    .baud_divisor       (baud_next),
    .baud_load          (wr && paddr == ADDR_BAUD),
    .double_speed_bit   (dbl_reg),
    .sync_mode          (sync_mode),
    .clock_slave        (!serial_clock_master),
    .clock_polarity_bit (csc_reg[CSC_POL]),
    .serial_clock_in    (xs2_reg),
    .clk_out            (serial_clock_pin_o),
    .tk                 (tk)
  );

  assign prdata  = rd_reg;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // Master sync mode clock goes out while live; otherwise serial_clock_port_oe sets the pin enable
  assign serial_clock_pin_oe = (live_reg && sync_mode && serial_clock_master)
                               ? 1'b1 : serial_clock_port_oe;
  assign serial_out_pin_o  = live_reg ? line_reg : port_out;
  assign serial_out_pin_oe = live_reg ? 1'b1 : port_oe;
  assign irq_buffer_empty  = global_irq_en && beie_reg && !full_reg;
  assign irq_tx_complete   = global_irq_en && tcie_reg && done_reg;
endmodule
`default_nettype wire

/* File: dv/ustx_sva.sv */
// Port-level checker for the serial transmitter, bound into ustx_top.
// Assumes one clock mclk and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module ustx_sva
  import ustx_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        global_irq_en,
  input wire logic        port_out,
  input wire logic        port_oe,
  input wire logic        serial_clock_port_oe,
  input wire logic        serial_clock_master,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe,
  input wire logic        serial_clock_pin_oe,
  input wire logic        irq_buffer_empty,
  input wire logic        irq_tx_complete,
  input wire logic        irq_tx_complete_ack
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_bus_answer_ok: assert property (pready && !pslverr)
    else $error("bus answer not ready or error");
  a_line_after_reset: assert property (disable iff (1'b0) reset ##1 !reset
    |-> serial_out_pin_o == port_out && serial_out_pin_oe == port_oe)
    else $error("pin not left to port after reset");
  a_rdata_after_reset: assert property (disable iff (1'b0) reset ##1 !reset |-> prdata == 32'h0)
    else $error("read data not zero after reset");
  a_data_reads_zero: assert property (psel && !penable && !pwrite && paddr == ADDR_DATA |=> prdata == 32'h0)
    else $error("data location read not zero");
  a_empty_gated: assert property (!global_irq_en |-> !irq_buffer_empty)
    else $error("empty request without global enable");
  a_done_gated: assert property (!global_irq_en |-> !irq_tx_complete)
    else $error("complete request without global enable");
  a_clock_pin_port: assert property (!serial_clock_master |-> serial_clock_pin_oe == serial_clock_port_oe)
    else $error("clock pin enable not from port");
  a_ack_clears_done: assert property (irq_tx_complete && irq_tx_complete_ack |=> !irq_tx_complete)
    else $error("complete request survives service");
  a_empty_holds: assert property (irq_buffer_empty && !(psel && pwrite) ##1 global_irq_en |-> irq_buffer_empty)
    else $error("empty request dropped without cause");
  a_done_holds: assert property (irq_tx_complete && !irq_tx_complete_ack && !(psel && pwrite) ##1 global_irq_en
    |-> irq_tx_complete)
    else $error("complete request dropped without cause");
endmodule
bind ustx_top ustx_sva i_sva (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .global_irq_en, .port_out, .port_oe, .serial_clock_port_oe, .serial_clock_master,
  .serial_out_pin_o, .serial_out_pin_oe,
  .serial_clock_pin_oe, .irq_buffer_empty, .irq_tx_complete, .irq_tx_complete_ack);
`default_nettype wire

/* File: dv/ustx_rx_model.sv */
// Remote receiver on the serial line: samples each bit mid-period.
// Assumes the bench gives the bit length in mclk cycles and the frame format.
`timescale 1ns/100ps
`default_nettype none
module ustx_rx_model (
  input wire logic  mclk,
  input wire logic  line,
  input wire logic  oe,
  input var int     bit_cyc,
  input var int     nbits,
  input wire logic  par_en,
  input wire logic  stop2,
  output logic [8:0] rx_data,
  output logic      rx_par,
  output logic      rx_stop,
  output int        rx_count
);
  logic [8:0] d;
  logic       p;
  logic       s;
  initial rx_count = 0;
  // Start, data LSB first, parity, stops
  always begin
    @(posedge mclk);
    if (oe === 1'b1 && line === 1'b0) begin
      d = 9'h0;
      p = 1'b0;
      repeat (bit_cyc / 2) @(posedge mclk);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge mclk);
        d[i] = line;
      end
      if (par_en) begin
        repeat (bit_cyc) @(posedge mclk);
        p = line;
      end
      repeat (bit_cyc) @(posedge mclk);
      s = line;
      if (stop2) begin
        repeat (bit_cyc) @(posedge mclk);
        s = s & line;
      end
      rx_data = d;
      rx_par = p;
      rx_stop = s;
      rx_count++;
    end
  end
endmodule
`default_nettype wire

/* File: dv/usart_transmitter_tb.sv */
// Self-checking bench: APB master, random frame formats, receiver model.
// Assumes ustx_top, its bound checker and ustx_rx_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module usart_transmitter_tb;
  import ustx_pkg::*;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, global_irq_en = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, d1, d2;
  logic pready, pslverr, port_out = 0, port_oe = 0, serial_clock_pin_i = 0;
  logic serial_clock_port_out = 0, serial_clock_port_oe = 0, serial_clock_master = 0;
  logic serial_out_pin_o, serial_out_pin_oe, serial_clock_pin_o, serial_clock_pin_oe;
  logic irq_buffer_empty, irq_tx_complete, irq_tx_complete_ack = 0;
  logic par_en = 0, odd = 0, stop2 = 0, dbl, rx_par, rx_stop;
  logic [8:0] rx_data;
  logic [2:0] sz;
  int mismatches = 0, num_checks = 0, bit_cyc = 16, nbits = 8, rx_count, dv;
  always #10 mclk = ~mclk;
  ustx_top i_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .global_irq_en, .port_out, .port_oe, .serial_clock_pin_i, .serial_clock_port_out,
    .serial_clock_port_oe, .serial_clock_master, .serial_out_pin_o, .serial_out_pin_oe,
    .serial_clock_pin_o, .serial_clock_pin_oe, .irq_buffer_empty, .irq_tx_complete,
    .irq_tx_complete_ack);
  ustx_rx_model i_rx (.mclk, .line(serial_out_pin_o), .oe(serial_out_pin_oe), .bit_cyc, .nbits,
    .par_en, .stop2, .rx_data, .rx_par, .rx_stop, .rx_count);
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [8:0] exp_word(input logic [31:0] d);
    return d[8:0] & 9'((1 << nbits) - 1);
  endfunction
  task automatic get_frame(input logic [31:0] d);
    int c0;
    int n;
    c0 = rx_count;
    n = 0;
    while (rx_count == c0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    chk(rx_count, c0 + 1, "frame count");
    chk(rx_data, exp_word(d), "data bits");
    if (par_en) chk(rx_par, ^exp_word(d) ^ odd, "parity bit");
    chk(rx_stop, 1, "stop bits");
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h877d));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    apb(0, ADDR_CSC, 0);
    chk(rd, {24'h0, CSC_RESET}, "format reset");
    apb(0, ADDR_CSA, 0);
    chk(rd, 32'h20, "status reset");
    apb(0, 8'h18, 0);
    chk(rd, 0, "unmapped read");
    apb(0, ADDR_DATA, 0);
    chk(rd, 0, "data reads zero");
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      sz = (i % 5 == 4) ? SIZE_NINE : 3'(i % 5);
      nbits = (sz == SIZE_NINE) ? 9 : sz + 5;
      {par_en, odd, stop2, dbl} = 4'($urandom);
      dv = $urandom_range(0, 2);
      bit_cyc = (dv + 1) * (dbl ? 8 : 16);
      // Port level stays idle high so a released pin never fakes a start bit
      port_out <= 1'b1;
      port_oe <= 1'($urandom);
      serial_clock_port_oe <= 1'($urandom);
      d1 = $urandom;
      d2 = $urandom;
      apb(1, ADDR_BAUD, dv);
      apb(1, ADDR_CSA, 32'(dbl) << CSA_DOUBLE | 32'h40);
      apb(1, ADDR_CSC, {24'h0, sz[2], 1'b0, par_en, odd, stop2, sz[1:0], 1'b0});
      apb(1, ADDR_CSB, 32'h8 | d1[8]);
      apb(1, ADDR_DATA, d1);
      apb(1, ADDR_CSB, 32'h8 | d2[8]);
      apb(1, ADDR_DATA, d2);
      apb(0, ADDR_CSA, 0);
      chk(rd[6:5], 2'b00, "buffer held");
      apb(1, ADDR_CSB, (i == 9 ? 32'h0 : 32'h8) | !d2[8]);
      chk(serial_out_pin_oe, 1, "pin taken");
      get_frame(d1);
      get_frame(d2);
      repeat (4 * bit_cyc) @(posedge mclk);
      apb(0, ADDR_CSA, 0);
      chk(rd[6:5], 2'b11, "all sent");
      chk(serial_out_pin_o, 1, "idle high");
      $display("test frame %0d done", i);
    end
    port_out <= 1'($urandom);
    port_oe <= 1'($urandom);
    @(posedge mclk);
    chk({serial_out_pin_o, serial_out_pin_oe}, {port_out, port_oe}, "pin released");
    apb(1, ADDR_CSB, 32'h68);
    global_irq_en <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({irq_tx_complete, irq_buffer_empty}, 2'b11, "requests");
    irq_tx_complete_ack <= 1'b1;
    @(posedge mclk);
    irq_tx_complete_ack <= 1'b0;
    @(posedge mclk);
    chk({irq_tx_complete, irq_buffer_empty}, 2'b01, "serviced");
    global_irq_en <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(irq_buffer_empty, 0, "gated");
    $display("test requests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
